// ===== rshd_port.sv
/*
  half-duplex rs-485 / rs-232 serial port with register port and led drive.
  assumes a 20 MHz clock, an external transceiver and a plain register master.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
// Functional notes
// - rate from 1200 to 38400 baud selectable
// - seven data bits only with parity
// - half duplex, echo suppressed while sending in rs-485 mode
// - floating bus idles high, no starts
// - leds follow real line levels only
// - rs-485 leds lit while signal low, cts led kept dark
// - rs-232 leds lit while signal low
`timescale 1ns/1ps
`include "rshd_regs.svh"
module rshd_port
  import rshd_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // line
  input  wire logic       rxd_in,
  input  wire logic       cts_n_in,
  output logic            txd_out,
  output logic            de_out,
  output logic            rts_n_out,
  // leds
  output logic            led_rx_out,
  output logic            led_tx_out,
  output logic            led_rts_out,
  output logic            led_cts_out
);
  // ********************************
  // registers
  // ********************************
  logic [6:0] ctrl;
  logic [6:0] next_ctrl;
  logic [7:0] rx_data;
  logic       rx_full, rx_perr, rx_ferr, cfg_err;
  logic       rx_s1, rx_s2, cts_s1, cts_s2;
  logic       tick;
  rshd_par_t  par;
  logic       bits8, mode485;
  assign par     = rshd_par_t'(ctrl[`RSHD_CTRL_PAR_LSB +: 2]);
  assign bits8   = ctrl[`RSHD_CTRL_BITS8_POS];
  assign mode485 = ctrl[`RSHD_CTRL_MODE_POS];

  rshd_baud_gen u_baud (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .baud_sel_in (ctrl[`RSHD_CTRL_BAUD_LSB +: 3]),
    .tick_out    (tick)
  );

  // pin synchronisers; reset value high is the fail-safe idle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_s1  <= 1'b1;
      rx_s2  <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end else begin
      rx_s1  <= rxd_in;
      rx_s2  <= rx_s1;
      cts_s1 <= cts_n_in;
      cts_s2 <= cts_s1;
    end
  end

  // ********************************
  // control write, config check
  // ********************************
  always_comb begin
    next_ctrl = ctrl;
    if (wr_in && addr_in == `RSHD_CTRL_ADDR) begin
      // seven bits without parity, or parity code 3, is refused
      if ((wdata_in[`RSHD_CTRL_BITS8_POS] || wdata_in[4:3] == 2'h1 || wdata_in[4:3] == 2'h2)
          && wdata_in[4:3] != 2'h3) begin
        next_ctrl = wdata_in[6:0];
      end
    end
  end

  // ********************************
  // transmitter
  // ********************************
  rshd_state_t tx_st, next_tx_st;
  logic [3:0]  tx_os, next_tx_os;
  logic [2:0]  tx_bit, next_tx_bit;
  logic [7:0]  tx_sh, next_tx_sh;
  logic        tx_par, next_tx_par;
  logic        next_txd, next_de;
  logic        tx_busy;
  assign tx_busy = (tx_st != RSHD_IDLE);

  always_comb begin
    next_tx_st  = tx_st;
    next_tx_os  = tx_os;
    next_tx_bit = tx_bit;
    next_tx_sh  = tx_sh;
    next_tx_par = tx_par;
    next_txd    = txd_out;
    next_de     = de_out;
    case (tx_st)
      RSHD_IDLE: begin
        next_txd = 1'b1;
        next_de  = 1'b0;
        if (wr_in && addr_in == `RSHD_TXDATA_ADDR) begin
          next_tx_sh  = wdata_in;
          next_tx_par = (par == RSHD_PAR_ODD);
          next_tx_st  = RSHD_START;
          next_tx_os  = 4'h0;
          next_txd    = 1'b0;
          next_de     = 1'b1;
        end
      end
      default: begin
        if (tick) begin
          next_tx_os = tx_os + 4'h1;
          if (tx_os == 4'hf) begin
            case (tx_st)
              RSHD_START, RSHD_DATA: begin
                if (tx_st == RSHD_DATA && tx_bit == (bits8 ? 3'h7 : 3'h6)) begin
                  next_tx_st = (par == RSHD_PAR_NONE) ? RSHD_STOP : RSHD_PARITY;
                  next_txd   = (par == RSHD_PAR_NONE) ? 1'b1 : tx_par;
                end else begin
                  if (tx_st == RSHD_DATA) begin
                    next_tx_bit = tx_bit + 3'h1;
                  end else begin
                    next_tx_bit = 3'h0;
                  end
                  next_tx_st  = RSHD_DATA;
                  next_txd    = tx_sh[0];
                  next_tx_par = tx_par ^ tx_sh[0];
                  next_tx_sh  = {1'b0, tx_sh[7:1]};
                end
              end
              RSHD_PARITY: begin
                next_tx_st = RSHD_STOP;
                next_txd   = 1'b1;
              end
              default: begin
                next_tx_st = RSHD_IDLE;
                next_de    = 1'b0;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st   <= RSHD_IDLE;
      tx_os   <= 4'h0;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_par  <= 1'b0;
      txd_out <= 1'b1;
      de_out  <= 1'b0;
      ctrl    <= `RSHD_CTRL_RESET;
    end else begin
      tx_st   <= next_tx_st;
      tx_os   <= next_tx_os;
      tx_bit  <= next_tx_bit;
      tx_sh   <= next_tx_sh;
      tx_par  <= next_tx_par;
      txd_out <= next_txd;
      de_out  <= next_de;
      ctrl    <= next_ctrl;
    end
  end

  // ********************************
  // receiver
  // ********************************
  rshd_state_t rx_st, next_rx_st;
  logic [3:0]  rx_os, next_rx_os;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_sh, next_rx_sh;
  logic        rx_par, next_rx_par;
  logic [7:0]  next_rx_data;
  logic        next_rx_full, next_rx_perr, next_rx_ferr, next_cfg_err;
  logic        echo;
  assign echo = mode485 && de_out;

  always_comb begin
    next_rx_st   = rx_st;
    next_rx_os   = rx_os;
    next_rx_bit  = rx_bit;
    next_rx_sh   = rx_sh;
    next_rx_par  = rx_par;
    next_rx_data = rx_data;
    next_rx_full = rx_full;
    next_rx_perr = rx_perr;
    next_rx_ferr = rx_ferr;
    next_cfg_err = cfg_err;
    if (rd_in && addr_in == `RSHD_RXDATA_ADDR) begin
      next_rx_full = 1'b0;
    end
    if (rd_in && addr_in == `RSHD_STAT_ADDR) begin
      next_rx_perr = 1'b0;
      next_rx_ferr = 1'b0;
      next_cfg_err = 1'b0;
    end
    if (wr_in && addr_in == `RSHD_CTRL_ADDR && next_ctrl == ctrl
        && wdata_in[6:0] != ctrl) begin
      next_cfg_err = 1'b1;
    end
    if (echo) begin
      next_rx_st = RSHD_IDLE;
    end else if (tick) begin
      next_rx_os = rx_os + 4'h1;
      case (rx_st)
        RSHD_IDLE: begin
          next_rx_os = 4'h0;
          if (!rx_s2) begin
            next_rx_st = RSHD_START;
          end
        end
        RSHD_START: begin
          if (rx_os == 4'h7) begin
            next_rx_os  = 4'h0;
            next_rx_bit = 3'h0;
            next_rx_par = (par == RSHD_PAR_ODD);
            next_rx_st  = rx_s2 ? RSHD_IDLE : RSHD_DATA;
          end
        end
        RSHD_DATA: begin
          if (rx_os == 4'hf) begin
            next_rx_sh  = bits8 ? {rx_s2, rx_sh[7:1]} : {1'b0, rx_s2, rx_sh[6:1]};
            next_rx_par = rx_par ^ rx_s2;
            next_rx_bit = rx_bit + 3'h1;
            if (rx_bit == (bits8 ? 3'h7 : 3'h6)) begin
              next_rx_st = (par == RSHD_PAR_NONE) ? RSHD_STOP : RSHD_PARITY;
            end
          end
        end
        RSHD_PARITY: begin
          if (rx_os == 4'hf) begin
            next_rx_par = rx_par ^ rx_s2;
            next_rx_st  = RSHD_STOP;
          end
        end
        default: begin
          if (rx_os == 4'hf) begin
            next_rx_st   = RSHD_IDLE;
            next_rx_data = rx_sh;
            next_rx_full = 1'b1;
            if (!rx_s2) begin
              next_rx_ferr = 1'b1;
            end
            if (par != RSHD_PAR_NONE && rx_par) begin
              next_rx_perr = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st   <= RSHD_IDLE;
      rx_os   <= 4'h0;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_par  <= 1'b0;
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      cfg_err <= 1'b0;
    end else begin
      rx_st   <= next_rx_st;
      rx_os   <= next_rx_os;
      rx_bit  <= next_rx_bit;
      rx_sh   <= next_rx_sh;
      rx_par  <= next_rx_par;
      rx_data <= next_rx_data;
      rx_full <= next_rx_full;
      rx_perr <= next_rx_perr;
      rx_ferr <= next_rx_ferr;
      cfg_err <= next_cfg_err;
    end
  end

  // ********************************
  // read port and leds
  // ********************************
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `RSHD_CTRL_ADDR:   next_rdata = {1'b0, ctrl};
        `RSHD_RXDATA_ADDR: next_rdata = rx_data;
        `RSHD_STAT_ADDR:   next_rdata = {2'h0, !cts_s2, cfg_err, rx_ferr, rx_perr,
                                         tx_busy, rx_full};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out   <= 8'h00;
      rts_n_out   <= 1'b1;
      led_rx_out  <= 1'b0;
      led_tx_out  <= 1'b0;
      led_rts_out <= 1'b0;
      led_cts_out <= 1'b0;
    end else begin
      rdata_out   <= next_rdata;
      rts_n_out   <= !next_de;
      led_rx_out  <= !rx_s2;
      led_tx_out  <= !txd_out;
      led_rts_out <= rts_n_out == 1'b0;
      led_cts_out <= !mode485 && !cts_s2;
    end
  end

  a_cts_dark: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mode485 |=> !led_cts_out) else $error("cts led lit in rs-485 mode");
  a_tx_led: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !txd_out |=> led_tx_out) else $error("tx led not following line");
  a_echo_block: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    echo |=> $stable(rx_full) || !rx_full) else $error("echo delivered");
  a_seven_bits: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !bits8 |-> par != RSHD_PAR_NONE) else $error("7 bits without parity");
  a_idle_high: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tx_st == RSHD_IDLE && !de_out |-> txd_out) else $error("line not idle high");
  a_rx_led: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rx_s2 |=> !led_rx_out) else $error("rx led lit on high line");
endmodule

// ===== rshd_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  half-duplex serial port. assumes a 20 MHz system clock.
*/
`ifndef RSHD_REGS_SVH
`define RSHD_REGS_SVH
// ********************************
// register offsets
// ********************************
`define RSHD_CTRL_ADDR   4'h0
`define RSHD_TXDATA_ADDR 4'h1
`define RSHD_RXDATA_ADDR 4'h2
`define RSHD_STAT_ADDR   4'h3
// ********************************
// control fields and reset
// ********************************
`define RSHD_CTRL_BAUD_LSB   0
`define RSHD_CTRL_PAR_LSB    3
`define RSHD_CTRL_BITS8_POS  5
`define RSHD_CTRL_MODE_POS   6
`define RSHD_CTRL_RESET      7'h63
// ********************************
// timing
// ********************************
`define RSHD_CLK_HZ          20000000
`define RSHD_OVS             16
`endif

// ===== rshd_pkg.sv
/*
  types of the half-duplex serial port.
  assumes rshd_regs.svh is included by the design files.
*/
package rshd_pkg;
  typedef enum logic [1:0] {RSHD_PAR_NONE, RSHD_PAR_ODD, RSHD_PAR_EVEN, RSHD_PAR_BAD} rshd_par_t;
  typedef enum {RSHD_IDLE, RSHD_START, RSHD_DATA, RSHD_PARITY, RSHD_STOP} rshd_state_t;
endpackage

// ===== rshd_baud_gen.sv
/*
  oversampling tick divider: one-cycle pulse at 16x the chosen bit rate.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
`include "rshd_regs.svh"
module rshd_baud_gen
  import rshd_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // rate select
  input  wire logic [2:0] baud_sel_in,
  // tick
  output logic            tick_out
);
  localparam int CW = 16;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;
  logic [CW-1:0] limit;

  // ********************************
  // divisor per rate
  // ********************************
  always_comb begin
    case (baud_sel_in)
      3'h0:    limit = CW'(`RSHD_CLK_HZ / (1200 * `RSHD_OVS) - 1);
      3'h1:    limit = CW'(`RSHD_CLK_HZ / (2400 * `RSHD_OVS) - 1);
      3'h2:    limit = CW'(`RSHD_CLK_HZ / (4800 * `RSHD_OVS) - 1);
      3'h3:    limit = CW'(`RSHD_CLK_HZ / (9600 * `RSHD_OVS) - 1);
      3'h4:    limit = CW'(`RSHD_CLK_HZ / (19200 * `RSHD_OVS) - 1);
      3'h5:    limit = CW'(`RSHD_CLK_HZ / (33600 * `RSHD_OVS) - 1);
      default: limit = CW'(`RSHD_CLK_HZ / (38400 * `RSHD_OVS) - 1);
    endcase
  end

  always_comb begin
    next_tick = (cnt >= limit);
    next_cnt  = next_tick ? '0 : cnt + 16'h0001;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

  a_tick_period: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tick_out |=> !tick_out) else $error("tick lasted over one cycle");
endmodule

// ===== rshd_peer.sv
/*
  far-side bus model: sends frames on the shared pair, samples ours.
  assumes one clock and a fail-safe bus that floats high.
*/
`timescale 1ns/1ps
module rshd_peer
  import rshd_pkg::*;
(
  // clock
  input  wire logic clock_in,
  // bus side of the port
  input  wire logic txd_in,
  input  wire logic de_in,
  output logic      rxd_out
);
  logic line_q = 1'b1;
  // ************
  // shared pair
  // ************
  // our own driver shows on the pair, an idle pair floats high
  assign rxd_out = de_in ? txd_in : line_q;
  // n bits lsb first, bc cycles each, then release
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      line_q <= f[i];
      repeat (bc) @(posedge clock_in);
    end
    line_q <= 1'b1;
  endtask
  // samples n bits at mid bit once a start edge is seen or 4 * bc cycles pass without one
  task automatic grab(input int n, input int bc, output logic [10:0] f);
    int k;
    f = '1;
    k = 0;
    while (txd_in === 1'b1 && k < 4 * bc) begin
      @(posedge clock_in);
      k++;
    end
    repeat (bc / 2) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      f[i] = de_in ? txd_in : 1'bx;
      repeat (bc) @(posedge clock_in);
    end
  endtask
endmodule

// ===== test_rshd_port.sv
/*
  self-checking bench of the half-duplex serial port.
  assumes the peer model on the pair and a 50 ns clock.
*/
`timescale 1ns/1ps
`include "rshd_regs.svh"
module test_rshd_port
  import rshd_pkg::*;
;
  logic       clock_in;
  logic       rst_n_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       rxd_in;
  logic       cts_n_in;
  logic       txd_out;
  logic       de_out;
  logic       rts_n_out;
  logic       led_rx_out;
  logic       led_tx_out;
  logic       led_rts_out;
  logic       led_cts_out;
  int         err_total;
  int         compares;
  localparam int BC38 = `RSHD_CLK_HZ / 38400;
  localparam int BC19 = `RSHD_CLK_HZ / 19200;

  rshd_port dut_u (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .addr_in     (addr_in),
    .wdata_in    (wdata_in),
    .wr_in       (wr_in),
    .rd_in       (rd_in),
    .rdata_out   (rdata_out),
    .rxd_in      (rxd_in),
    .cts_n_in    (cts_n_in),
    .txd_out     (txd_out),
    .de_out      (de_out),
    .rts_n_out   (rts_n_out),
    .led_rx_out  (led_rx_out),
    .led_tx_out  (led_tx_out),
    .led_rts_out (led_rts_out),
    .led_cts_out (led_cts_out)
  );
  rshd_peer peer_u (
    .clock_in (clock_in),
    .txd_in   (txd_out),
    .de_in    (de_out),
    .rxd_out  (rxd_in)
  );

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // ************
  // helpers
  // ************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
    d = rdata_out;
  endtask
  function automatic logic [7:0] cfg(input logic m, input logic b8, input logic [1:0] p,
                                     input logic [2:0] r);
    return {1'b0, m, b8, p, r};
  endfunction
  // start, data lsb first, optional parity, one stop
  function automatic int mk(input logic [7:0] d, input logic b8, input logic [1:0] p,
                            output logic [10:0] f);
    int   n;
    logic pb;
    n = b8 ? 8 : 7;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i+1] = d[i];
    pb = b8 ? ^d : ^d[6:0];
    if (p != 2'd0) begin
      f[n+1] = (p == 2'd1) ? ~pb : pb;
      n++;
    end
    return n + 2;
  endfunction

  // ************
  // scenarios
  // ************
  task automatic t_reset;
    logic [7:0] s;
    chk("pins", 8'h50, {1'b0, txd_out, de_out, rts_n_out, led_rx_out, led_tx_out,
        led_rts_out, led_cts_out});
    rd(`RSHD_CTRL_ADDR, s);
    chk("ctrl", 8'(`RSHD_CTRL_RESET), s);
    repeat (600) @(posedge clock_in);
    rd(`RSHD_STAT_ADDR, s);
    chk("idle stat", 8'h00, s & 8'h0d);
  endtask
  task automatic t_refuse;
    logic [7:0] s;
    wr(`RSHD_CTRL_ADDR, cfg(1'b1, 1'b0, 2'd0, 3'd6));
    rd(`RSHD_CTRL_ADDR, s);
    chk("ctrl kept", 8'(`RSHD_CTRL_RESET), s);
    rd(`RSHD_STAT_ADDR, s);
    chk("refused", 8'h10, s & 8'h10);
    wr(`RSHD_CTRL_ADDR, cfg(1'b1, 1'b1, 2'd3, 3'd6));
    rd(`RSHD_STAT_ADDR, s);
    chk("refused", 8'h10, s & 8'h10);
    rd(`RSHD_STAT_ADDR, s);
    chk("cleared", 8'h00, s & 8'h10);
  endtask
  task automatic t_tx(input logic b8, input logic [1:0] p, input logic [2:0] r,
                      input int bc, input logic [7:0] d);
    logic [10:0] f;
    logic [10:0] g;
    logic [7:0]  s;
    int          n;
    n = mk(d, b8, p, f);
    wr(`RSHD_CTRL_ADDR, cfg(1'b1, b8, p, r));
    wr(`RSHD_TXDATA_ADDR, d);
    repeat (4) @(posedge clock_in);
    chk("tx pins", 8'h0b, {3'h0, txd_out, de_out, rts_n_out, led_tx_out, led_rts_out});
    rd(`RSHD_STAT_ADDR, s);
    chk("busy", 8'h02, s & 8'h02);
    peer_u.grab(n, bc, g);
    chk("frame lo", f[7:0], g[7:0]);
    chk("frame hi", {5'h0, f[10:8]}, {5'h0, g[10:8]});
    chk("de end", 8'h00, {7'h0, de_out});
    rd(`RSHD_STAT_ADDR, s);
    chk("echo", 8'h00, s & 8'h03);
  endtask
  task automatic t_rx(input logic b8, input logic [1:0] p, input logic [7:0] d,
                      input logic [10:0] flip, input logic [7:0] e);
    logic [10:0] f;
    logic [7:0]  s;
    logic [7:0]  m;
    int          n;
    n = mk(d, b8, p, f);
    m = b8 ? 8'hff : 8'h7f;
    wr(`RSHD_CTRL_ADDR, cfg(1'b1, b8, p, 3'd6));
    fork
      peer_u.send(f ^ flip, n, BC38);
      begin
        repeat (10) @(posedge clock_in);
        chk("rx led", 8'h01, {7'h0, led_rx_out});
      end
    join
    repeat (BC38) @(posedge clock_in);
    rd(`RSHD_STAT_ADDR, s);
    chk("rx err", e, s & 8'h0c);
    if (e == 8'h00) begin
      chk("rx full", 8'h01, s & 8'h01);
      rd(`RSHD_RXDATA_ADDR, s);
      chk("rx data", d & m, s & m);
    end
  endtask
  task automatic t_cts;
    logic [7:0] s;
    cts_n_in <= 1'b0;
    wr(`RSHD_CTRL_ADDR, cfg(1'b1, 1'b1, 2'd0, 3'd6));
    repeat (4) @(posedge clock_in);
    chk("cts 485", 8'h00, {7'h0, led_cts_out});
    wr(`RSHD_CTRL_ADDR, cfg(1'b0, 1'b1, 2'd0, 3'd6));
    repeat (4) @(posedge clock_in);
    chk("cts 232", 8'h01, {7'h0, led_cts_out});
    rd(`RSHD_STAT_ADDR, s);
    chk("cts stat", 8'h20, s & 8'h20);
    cts_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk("cts off", 8'h00, {7'h0, led_cts_out});
  endtask
  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n_in  = 1'b0;
    addr_in   = 4'h0;
    wdata_in  = 8'h00;
    wr_in     = 1'b0;
    rd_in     = 1'b0;
    cts_n_in  = 1'b1;
    err_total = 0;
    compares  = 0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_refuse;
    t_tx(1'b1, 2'd0, 3'd6, BC38, 8'ha5);
    t_tx(1'b0, 2'd1, 3'd6, BC38, 8'h35);
    t_tx(1'b1, 2'd2, 3'd4, BC19, 8'hc3);
    t_rx(1'b1, 2'd2, 8'h96, 11'h000, 8'h00);
    t_rx(1'b0, 2'd1, 8'h4b, 11'h000, 8'h00);
    t_rx(1'b1, 2'd1, 8'h5a, 11'h200, 8'h04);
    t_rx(1'b1, 2'd0, 8'h3c, 11'h200, 8'h08);
    t_cts;
    complete_run;
  end

  initial begin
    repeat (80000) @(posedge clock_in);
    err_total++;
    $display("Error watchdog expected done seen timeout");
    complete_run;
  end
endmodule
